// >>> shared/ptm_cfg.svh
// constants of the periodic timer pulse and capture block
`ifndef PTM_CFG_SVH
`define PTM_CFG_SVH

`define PTM_CW          10
`define PTM_CNT_ZERO    10'h000
`define PTM_CNT_ONE     10'h001
`define PTM_CNT_MAX     10'h3ff

`define PTM_ADDR_W      5
`define PTM_DATA_W      32
`define PTM_STRB_W      4
`define PTM_OFF_CTRL    5'h00
`define PTM_OFF_STATUS  5'h04
`define PTM_OFF_COUNT   5'h08
`define PTM_OFF_CMPA    5'h0c
`define PTM_OFF_CMPP    5'h10
`define PTM_ALIGN_ZERO  2'h0

`define PTM_RESP_OKAY   2'h0
`define PTM_RESP_DECERR 2'h3

`define PTM_MODE_CMP    2'h0
`define PTM_MODE_CAP    2'h1
`define PTM_MODE_SPULSE 2'h2
`define PTM_MODE_TMR    2'h3

`define PTM_IO_RISE     2'h0
`define PTM_IO_FALL     2'h1
`define PTM_IO_BOTH     2'h2
`define PTM_IO_NONE     2'h3

`define PTM_CTRL_RST    8'h00
`define PTM_CTRL_LO_W   4
`define PTM_RUN_POS     4
`define PTM_CTRL_HI_POS 5
`define PTM_CTRL_HI_W   4
`define PTM_FLAG_A_POS  0
`define PTM_FLAG_P_POS  1
`define PTM_WORD_ZERO   32'h0000_0000

`endif

// >>> shared/ptm_pkg.sv
// types of the periodic timer pulse and capture block
`include "ptm_cfg.svh"
package ptm_pkg;

  typedef logic [`PTM_CW-1:0] count_t;

  typedef struct packed {
    logic output_polarity_invert;
    logic output_initial_level;
    logic counter_clear_select;
    logic capture_source_select;
    logic pin_io_select_hi;
    logic pin_io_select_lo;
    logic timer_mode_select_hi;
    logic timer_mode_select_lo;
  } ctrl_t;

  typedef struct packed {
    logic [`PTM_DATA_W-1:0] data;
    logic [`PTM_STRB_W-1:0] strb;
  } axi_w_t;

  typedef struct packed {
    logic [`PTM_DATA_W-1:0] data;
    logic [1:0]             resp;
  } axi_r_t;

endpackage

// >>> design/edge_sync.sv
// two-flop pin synchroniser with edge pulses
`timescale 1ns/1ps
module edge_sync (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_rise,
  output logic      o_fall
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign o_rise = sync_reg & ~prev_reg;
  assign o_fall = ~sync_reg & prev_reg;

endmodule

// >>> design/periodic_timer_pulse_capture.sv
// 10-bit timer: single-pulse output and capture input, axi4-lite registers
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ptm_cfg.svh"
module periodic_timer_pulse_capture (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_s_axi_awvalid,
  output logic                        o_s_axi_awready,
  input  wire logic [`PTM_ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                   i_s_axi_wvalid,
  output logic                        o_s_axi_wready,
  input  wire ptm_pkg::axi_w_t        i_s_axi_w,
  output logic                        o_s_axi_bvalid,
  input  wire logic                   i_s_axi_bready,
  output logic [1:0]                  o_s_axi_bresp,
  input  wire logic                   i_s_axi_arvalid,
  output logic                        o_s_axi_arready,
  input  wire logic [`PTM_ADDR_W-1:0] i_s_axi_araddr,
  output logic                        o_s_axi_rvalid,
  input  wire logic                   i_s_axi_rready,
  output ptm_pkg::axi_r_t             o_s_axi_r,
  input  wire logic                   i_external_clock_pin,
  input  wire logic                   i_capture_input_pin,
  output logic                        o_timer_out
);

  ptm_pkg::ctrl_t         ctrl_reg;
  ptm_pkg::count_t        count_reg;
  ptm_pkg::count_t        compare_a_value_reg;
  ptm_pkg::count_t        compare_p_value_reg;
  logic                   counter_run_bit_reg;
  logic                   run_d_reg;
  logic                   compare_a_flag_reg;
  logic                   compare_p_flag_reg;
  logic                   cap_pend_reg;
  logic                   out_reg;
  logic                   aw_held_reg;
  logic                   w_held_reg;
  logic [`PTM_ADDR_W-1:0] waddr_reg;
  ptm_pkg::axi_w_t        wbeat_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  ptm_pkg::axi_r_t        rbeat_reg;

  logic                   ext_rise;
  logic                   ext_fall;
  logic                   cap_rise;
  logic                   cap_fall;
  logic [1:0]             mode;
  logic [1:0]             pin_io;
  logic                   mode_sp;
  logic                   mode_cap;
  logic                   run_rise;
  logic                   match_a;
  logic                   wrap_p;
  logic                   src_rise;
  logic                   src_fall;
  logic                   cap_edge;
  logic                   ext_trigger;
  logic                   act_lvl;
  logic                   do_write;
  logic [`PTM_ADDR_W-1:0] waddr_al;
  logic [`PTM_ADDR_W-1:0] raddr_al;
  logic                   wr_ctrl;
  logic                   wr_status;
  logic                   wr_cmpa;
  logic                   wr_cmpp;
  logic                   wr_hit;
  logic [`PTM_DATA_W-1:0] wmask;
  logic [`PTM_DATA_W-1:0] ctrl_word;
  logic [`PTM_DATA_W-1:0] status_word;
  logic [`PTM_DATA_W-1:0] ctrl_new;
  logic [`PTM_DATA_W-1:0] cmpa_new;
  logic [`PTM_DATA_W-1:0] cmpp_new;
  logic [`PTM_DATA_W-1:0] rd_word;
  logic                   rd_hit;

  edge_sync u_ext_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_external_clock_pin),
    .o_rise    (ext_rise),
    .o_fall    (ext_fall)
  );

  edge_sync u_cap_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_capture_input_pin),
    .o_rise    (cap_rise),
    .o_fall    (cap_fall)
  );

  // mode decode
  assign mode     = {ctrl_reg.timer_mode_select_hi, ctrl_reg.timer_mode_select_lo};
  assign pin_io   = {ctrl_reg.pin_io_select_hi, ctrl_reg.pin_io_select_lo};
  assign mode_sp  = (mode == `PTM_MODE_SPULSE);
  assign mode_cap = (mode == `PTM_MODE_CAP);
  assign run_rise = counter_run_bit_reg & ~run_d_reg;
  assign act_lvl  = ctrl_reg.output_initial_level ^ ctrl_reg.output_polarity_invert;

  // comparators
  assign match_a = mode_sp & counter_run_bit_reg & ~run_rise & (count_reg == compare_a_value_reg);
  assign wrap_p  = mode_cap & counter_run_bit_reg & ~run_rise &
                   ((compare_p_value_reg == `PTM_CNT_ZERO) ? (count_reg == `PTM_CNT_MAX)
                                                           : (count_reg == compare_p_value_reg));

  // capture edge select
  assign src_rise    = ctrl_reg.capture_source_select ? ext_rise : cap_rise;
  assign src_fall    = ctrl_reg.capture_source_select ? ext_fall : cap_fall;
  assign ext_trigger = mode_sp & ext_rise;

  always_comb begin
    cap_edge = 1'b0;
    if (mode_cap) begin
      case (pin_io)
        `PTM_IO_RISE: cap_edge = src_rise;
        `PTM_IO_FALL: cap_edge = src_fall;
        `PTM_IO_BOTH: cap_edge = src_rise | src_fall;
        default:      cap_edge = 1'b0;
      endcase
    end
  end

  // axi write side
  assign o_s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign o_s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign o_s_axi_bvalid  = bvalid_reg;
  assign o_s_axi_bresp   = bresp_reg;
  assign do_write        = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign waddr_al        = {waddr_reg[`PTM_ADDR_W-1:2], `PTM_ALIGN_ZERO};
  assign wr_ctrl         = do_write & (waddr_al == `PTM_OFF_CTRL);
  assign wr_status       = do_write & (waddr_al == `PTM_OFF_STATUS);
  assign wr_cmpa         = do_write & (waddr_al == `PTM_OFF_CMPA);
  assign wr_cmpp         = do_write & (waddr_al == `PTM_OFF_CMPP);
  assign wr_hit          = wr_ctrl | wr_status | wr_cmpa | wr_cmpp |
                           (waddr_al == `PTM_OFF_COUNT);

  genvar gi;
  generate
    for (gi = 0; gi < `PTM_STRB_W; gi++) begin : g_mask
      assign wmask[gi*8 +: 8] = {8{wbeat_reg.strb[gi]}};
    end
  endgenerate

  assign ctrl_word   = {{(`PTM_DATA_W-`PTM_CTRL_HI_POS-`PTM_CTRL_HI_W){1'b0}},
                        ctrl_reg[`PTM_CTRL_HI_W+`PTM_CTRL_LO_W-1:`PTM_CTRL_LO_W],
                        counter_run_bit_reg, ctrl_reg[`PTM_CTRL_LO_W-1:0]};
  assign status_word = {{(`PTM_DATA_W-2){1'b0}}, compare_p_flag_reg, compare_a_flag_reg};
  assign ctrl_new    = (ctrl_word & ~wmask) | (wbeat_reg.data & wmask);
  assign cmpa_new    = ({{(`PTM_DATA_W-`PTM_CW){1'b0}}, compare_a_value_reg} & ~wmask) |
                       (wbeat_reg.data & wmask);
  assign cmpp_new    = ({{(`PTM_DATA_W-`PTM_CW){1'b0}}, compare_p_value_reg} & ~wmask) |
                       (wbeat_reg.data & wmask);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      aw_held_reg <= 1'b0;
      waddr_reg   <= `PTM_OFF_CTRL;
    end else if (o_s_axi_awready && i_s_axi_awvalid) begin
      aw_held_reg <= 1'b1;
      waddr_reg   <= i_s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      w_held_reg <= 1'b0;
      wbeat_reg  <= '0;
    end else if (o_s_axi_wready && i_s_axi_wvalid) begin
      w_held_reg <= 1'b1;
      wbeat_reg  <= i_s_axi_w;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `PTM_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `PTM_RESP_OKAY : `PTM_RESP_DECERR;
    end else if (i_s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // axi read side
  assign o_s_axi_arready = ~rvalid_reg;
  assign o_s_axi_rvalid  = rvalid_reg;
  assign o_s_axi_r       = rbeat_reg;
  assign raddr_al        = {i_s_axi_araddr[`PTM_ADDR_W-1:2], `PTM_ALIGN_ZERO};

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = `PTM_WORD_ZERO;
    case (raddr_al)
      `PTM_OFF_CTRL:   rd_word = ctrl_word;
      `PTM_OFF_STATUS: rd_word = status_word;
      `PTM_OFF_COUNT:  rd_word = {{(`PTM_DATA_W-`PTM_CW){1'b0}}, count_reg};
      `PTM_OFF_CMPA:   rd_word = {{(`PTM_DATA_W-`PTM_CW){1'b0}}, compare_a_value_reg};
      `PTM_OFF_CMPP:   rd_word = {{(`PTM_DATA_W-`PTM_CW){1'b0}}, compare_p_value_reg};
      default:         rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rvalid_reg <= 1'b0;
      rbeat_reg  <= '0;
    end else if (i_s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg     <= 1'b1;
      rbeat_reg.data <= rd_word;
      rbeat_reg.resp <= rd_hit ? `PTM_RESP_OKAY : `PTM_RESP_DECERR;
    end else if (i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // control fields
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ctrl_reg <= `PTM_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= {ctrl_new[`PTM_CTRL_HI_POS+`PTM_CTRL_HI_W-1:`PTM_CTRL_HI_POS],
                   ctrl_new[`PTM_CTRL_LO_W-1:0]};
    end
  end

  // run bit: match clear, then pin trigger, then software
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      counter_run_bit_reg <= 1'b0;
      run_d_reg           <= 1'b0;
    end else begin
      run_d_reg <= counter_run_bit_reg;
      if (match_a) begin
        counter_run_bit_reg <= 1'b0;
      end else if (ext_trigger) begin
        counter_run_bit_reg <= 1'b1;
      end else if (wr_ctrl) begin
        counter_run_bit_reg <= ctrl_new[`PTM_RUN_POS];
      end
    end
  end

  // 10-bit counter
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      count_reg <= `PTM_CNT_ZERO;
    end else if (run_rise) begin
      count_reg <= `PTM_CNT_ZERO;
    end else if (wrap_p) begin
      count_reg <= `PTM_CNT_ZERO;
    end else if (counter_run_bit_reg && !match_a) begin
      count_reg <= count_reg + `PTM_CNT_ONE;
    end
  end

  // compare registers, capture beats software
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      compare_a_value_reg <= `PTM_CNT_ZERO;
    end else if (cap_edge) begin
      compare_a_value_reg <= count_reg;
    end else if (wr_cmpa) begin
      compare_a_value_reg <= cmpa_new[`PTM_CW-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      compare_p_value_reg <= `PTM_CNT_ZERO;
    end else if (wr_cmpp) begin
      compare_p_value_reg <= cmpp_new[`PTM_CW-1:0];
    end
  end

  // flags: write one clears, set wins
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cap_pend_reg       <= 1'b0;
      compare_a_flag_reg <= 1'b0;
      compare_p_flag_reg <= 1'b0;
    end else begin
      cap_pend_reg <= cap_edge;
      if (match_a || cap_pend_reg) begin
        compare_a_flag_reg <= 1'b1;
      end else if (wr_status && wmask[`PTM_FLAG_A_POS] && wbeat_reg.data[`PTM_FLAG_A_POS]) begin
        compare_a_flag_reg <= 1'b0;
      end
      if (wrap_p) begin
        compare_p_flag_reg <= 1'b1;
      end else if (wr_status && wmask[`PTM_FLAG_P_POS] && wbeat_reg.data[`PTM_FLAG_P_POS]) begin
        compare_p_flag_reg <= 1'b0;
      end
    end
  end

  // output pin
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      out_reg <= 1'b0;
    end else if (mode_sp) begin
      out_reg <= counter_run_bit_reg ? act_lvl : ~act_lvl;
    end else begin
      out_reg <= 1'b0;
    end
  end

  assign o_timer_out = out_reg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  chk_run_zeroes_count: assert property (run_rise |=> count_reg == `PTM_CNT_ZERO)
    else $error("counter not zeroed at run rise");
  chk_pin_trigger_run: assert property (ext_trigger && !match_a |=> counter_run_bit_reg)
    else $error("pin trigger did not set run bit");
  chk_match_ends_pulse: assert property (match_a |=> !counter_run_bit_reg && compare_a_flag_reg
                                         ##1 o_timer_out == ~$past(act_lvl))
    else $error("compare a match did not end the pulse");
  chk_pulse_trailing: assert property (mode_sp && $fell(counter_run_bit_reg) && $stable(ctrl_reg)
                                       |=> o_timer_out == ~act_lvl)
    else $error("pulse not ended when run cleared");
  chk_pulse_active: assert property (mode_sp && counter_run_bit_reg && $stable(ctrl_reg)
                                     |=> o_timer_out == $past(act_lvl))
    else $error("pulse level wrong while running");
  chk_sp_no_pflag: assert property (mode_sp && !compare_p_flag_reg |=> !compare_p_flag_reg)
    else $error("period flag set in single pulse");
  chk_capture_latch: assert property (cap_edge |=> compare_a_value_reg == $past(count_reg)
                                      ##1 compare_a_flag_reg)
    else $error("capture not latched or flagged");
  chk_period_wrap: assert property (wrap_p |=> count_reg == `PTM_CNT_ZERO && compare_p_flag_reg)
    else $error("period match did not wrap");
  chk_cap_disabled: assert property (mode_cap && pin_io == `PTM_IO_NONE && !wr_cmpa
                                     |=> $stable(compare_a_value_reg))
    else $error("capture with edge select off");
  chk_cap_source: assert property (mode_cap && pin_io == `PTM_IO_RISE &&
                                   (ctrl_reg.capture_source_select ? ext_rise : cap_rise)
                                   |=> compare_a_value_reg == $past(count_reg))
    else $error("selected source did not capture");
  chk_cap_free_run: assert property (mode_cap && counter_run_bit_reg && !run_rise && !wrap_p
                                     |=> count_reg == $past(count_reg) + `PTM_CNT_ONE)
    else $error("capture counter did not advance");
  chk_cap_no_output: assert property (mode_cap && $stable(ctrl_reg) |=> !o_timer_out)
    else $error("output driven in capture mode");

  cov_single_pulse: cover property (run_rise ##[1:20] match_a);
  cov_pin_trigger: cover property (ext_trigger ##[1:20] match_a);
  cov_capture: cover property (cap_edge ##1 cap_pend_reg);
  cov_period_wrap: cover property (wrap_p);

endmodule

// >>> verification/pin_source.sv
// pin stimulus source for the trigger and capture pins
`timescale 1ns/1ps
module pin_source (
  input  wire logic       i_ref_clk,
  input  wire logic       i_go,
  input  wire logic       i_sel,
  input  wire logic [3:0] i_width,
  output logic            o_external_clock_pin,
  output logic            o_capture_input_pin
);
  logic [3:0] left_reg;
  logic       sel_reg;
  initial begin
    left_reg = 4'h0;
    sel_reg  = 1'b0;
  end
  // pulse held for the width asked in clocks, one clock at width one, none at zero
  always @(posedge i_ref_clk) begin
    if (i_go) begin
      left_reg <= i_width;
      sel_reg  <= i_sel;
    end else if (left_reg != 4'h0) begin
      left_reg <= left_reg - 4'h1;
    end
  end
  // pins pulled low when idle
  assign o_external_clock_pin = (left_reg != 4'h0) && sel_reg;
  assign o_capture_input_pin  = (left_reg != 4'h0) && !sel_reg;
endmodule

// >>> verification/periodic_timer_pulse_capture_test.sv
// self-checking bench for the timer pulse and capture block
`timescale 1ns/1ps
`include "ptm_cfg.svh"
module periodic_timer_pulse_capture_test;
  logic                   ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, go, sel;
  logic                   awready, wready, bvalid, arready, rvalid, ext_pin, cap_pin, timer_out;
  logic [`PTM_ADDR_W-1:0] awaddr, araddr;
  logic [1:0]             bresp, resp;
  logic [3:0]             width;
  ptm_pkg::axi_w_t        w;
  ptm_pkg::axi_r_t        r;
  logic [31:0]            seed, rd, base;
  int                     fails, checks_done, k, na, dly, lo, io;
  int                     shadow[5];

  periodic_timer_pulse_capture dut_u (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_w(w),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_r(r),
    .i_external_clock_pin(ext_pin), .i_capture_input_pin(cap_pin), .o_timer_out(timer_out));
  pin_source src_u (.i_ref_clk(ref_clk), .i_go(go), .i_sel(sel), .i_width(width),
    .o_external_clock_pin(ext_pin), .o_capture_input_pin(cap_pin));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > 50) begin
      fails++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int   n;
    n = 0;
    tb = 1'b0;
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    w       <= '{data: d, strb: 4'hf};
    bready  <= 1'b1;
    while (!tb) begin
      @(negedge ref_clk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      resp = bresp;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      guard(n);
    end
    if (a < 5'h14) shadow[a >> 2] = d;
  endtask

  task automatic rdr(input logic [4:0] a);
    logic ta, tr;
    int   n;
    n = 0;
    tr = 1'b0;
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    while (!tr) begin
      @(negedge ref_clk);
      ta = arready;
      tr = rvalid;
      rd = r.data;
      resp = r.resp;
      @(posedge ref_clk);
      if (ta) arvalid <= 1'b0;
      guard(n);
    end
  endtask

  task automatic rreg(input logic [4:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask

  task automatic pin_is(input logic e);
    @(negedge ref_clk);
    chk({31'h0, timer_out}, {31'h0, e});
    @(posedge ref_clk);
  endtask

  task automatic pulse(input logic s);
    go <= 1'b1;
    sel <= s;
    width <= 4'h6;
    @(posedge ref_clk);
    go <= 1'b0;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (12000) @(posedge ref_clk);
    fails++;
    end_sim();
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, go, sel} = 8'h00;
    {awaddr, araddr, width} = 14'h0000;
    w = '0;
    seed = 32'h0000_0053;
    fails = 0;
    checks_done = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // reset values and unmapped places
    for (k = 0; k < 5; k++) if (k != 2) rreg(5'(k * 4), 32'h0000_0000);
    chk(32'(resp), 32'h0000_0000);
    rreg(5'h14, 32'h0000_0000);
    chk(32'(resp), 32'h0000_0003);
    wr(5'h14, 32'h0000_00ff);
    chk(32'(resp), 32'h0000_0003);
    $display("test registers done");
    // single pulse, every level and polarity
    for (k = 0; k < 4; k++) begin
      na = 3 + int'(xs() % 16);
      wr(5'h04, 32'h0000_0003);
      chk(32'(resp), 32'h0000_0000);
      wr(5'h0c, 32'(na));
      wr(5'h10, 32'h0000_0002);
      base = 32'h0000_000e | (32'(k) << 7);
      wr(5'h00, base);
      pin_is(!(k[0] ^ k[1]));
      wr(5'h00, base | 32'h0000_0010);
      pin_is(k[0] ^ k[1]);
      repeat (40) @(posedge ref_clk);
      pin_is(!(k[0] ^ k[1]));
      rreg(5'h00, shadow[0] & 32'h0000_01ef);
      rreg(5'h04, 32'h0000_0001);
      rreg(5'h08, 32'(na));
    end
    $display("test single pulse done");
    wr(5'h0c, 32'h0000_03ff);
    wr(5'h04, 32'h0000_0003);
    wr(5'h00, 32'h0000_001e);
    repeat (5) @(posedge ref_clk);
    wr(5'h00, 32'h0000_000e);
    pin_is(1'b1);
    rdr(5'h08);
    base = rd;
    repeat (3) @(posedge ref_clk);
    rreg(5'h08, base);
    rreg(5'h04, 32'h0000_0000);
    $display("test software clear done");
    wr(5'h0c, 32'h0000_0014);
    wr(5'h00, 32'h0000_008e);
    pulse(1'b1);
    repeat (6) @(posedge ref_clk);
    pin_is(1'b1);
    repeat (40) @(posedge ref_clk);
    rreg(5'h04, 32'h0000_0001);
    rreg(5'h00, 32'h0000_008e);
    $display("test pin trigger done");
    // capture on each edge choice and source
    wr(5'h10, 32'h0000_0000);
    for (k = 0; k < 8; k++) begin
      io = k % 4;
      base = 32'h0000_0001 | 32'(io << 2) | 32'((k / 4) << 5);
      wr(5'h00, base);
      wr(5'h04, 32'h0000_0003);
      wr(5'h00, base | 32'h0000_0010);
      dly = int'(xs() % 16);
      repeat (dly) @(posedge ref_clk);
      pulse(k[2]);
      repeat (20) @(posedge ref_clk);
      rreg(5'h04, 32'(io != 3));
      lo = dly + ((io != 0) ? 6 : 0);
      rdr(5'h0c);
      if (io != 3) chk(32'(rd >= lo && rd <= lo + 6), 32'h0000_0001);
      wr(5'h04, 32'h0000_0003);
      pulse(!k[2]);
      repeat (12) @(posedge ref_clk);
      rreg(5'h04, 32'h0000_0000);
      pin_is(1'b0);
    end
    $display("test capture done");
    for (k = 0; k < 2; k++) begin
      wr(5'h00, 32'h0000_0001);
      wr(5'h10, (k == 0) ? 32'h0000_0014 : 32'h0000_0000);
      wr(5'h04, 32'h0000_0003);
      wr(5'h00, 32'h0000_0011);
      repeat ((k == 0) ? 50 : 900) @(posedge ref_clk);
      rreg(5'h04, (k == 0) ? 32'h0000_0002 : 32'h0000_0000);
    end
    repeat (200) @(posedge ref_clk);
    rreg(5'h04, 32'h0000_0002);
    $display("test period done");
    end_sim();
  end
endmodule
